// File: asb_consts.svh
`ifndef ASB_CONSTS_SVH
`define ASB_CONSTS_SVH

// ****************************************
// Rate divider constants
// ****************************************
`define ASB_PR_SEL0 4'h1
`define ASB_PR_SEL1 4'h3
`define ASB_PR_SEL2 4'h4
`define ASB_PR_SEL3 4'hd
`define ASB_EXT_BYPASS 8'h00
`define ASB_DIV_RESET 19'h00000

// ****************************************
// Oversampling and frame constants
// ****************************************
`define ASB_LAST_TICK 4'hf
`define ASB_SAMPLE_FIRST 4'h7
`define ASB_SAMPLE_LAST 4'h9
`define ASB_START_TICK 4'h1
`define ASB_RX_LAST_BIT8 4'h7
`define ASB_RX_LAST_BIT9 4'h8
`define ASB_TX_LAST_BIT8 4'h9
`define ASB_TX_LAST_BIT9 4'ha
`define ASB_IDLE_TICKS8 8'ha0
`define ASB_IDLE_TICKS9 8'hb0

// ****************************************
// Buffer and reset values
// ****************************************
`define ASB_WORD_W 9
`define ASB_FIFO_DEPTH 8
`define ASB_LINE_IDLE 1'b1

`endif

// File: asb_pkg.sv
package asb_pkg;

    // Receive frame phase
    typedef enum logic [1:0] {
        ph_idle = 2'b00,
        ph_start = 2'b01,
        ph_data = 2'b10,
        ph_stop = 2'b11
    } asb_rx_phase_t;

    // Rate setup: common prescale, separate divisor and extension per direction
    typedef struct packed {
        logic [1:0] common_prescale_sel;
        logic [2:0] tx_divisor_sel;
        logic [2:0] rx_divisor_sel;
        logic [7:0] tx_ext_prescale_reg;
        logic [7:0] rx_ext_prescale_reg;
    } asb_baud_t;

    // Frame format
    typedef struct packed {
        logic word9;
        logic parity_enable;
        logic odd_parity_select;
    } asb_fmt_t;

    // Interrupt enables
    typedef struct packed {
        logic tx_empty_irq_enable;
        logic tx_complete_irq_enable;
        logic rx_irq_enable;
        logic idle_irq_enable;
        logic parity_irq_enable;
    } asb_irq_en_t;

    // Status flags, most significant first
    typedef struct packed {
        logic tx_empty_flag;
        logic tx_complete_flag;
        logic rx_full_flag;
        logic idle_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_flag;
        logic parity_error_flag;
    } asb_status_t;

    // Whole state of the serial core
    typedef struct packed {
        logic rx_meta;
        logic rx_sync;
        logic [18:0] tx_div;
        logic [18:0] rx_div;
        logic tx_busy;
        logic [3:0] tx_tick;
        logic [3:0] tx_bit;
        logic [10:0] tx_shift;
        logic tx_word9;
        logic tx_line;
        asb_rx_phase_t rx_ph;
        logic [3:0] rx_tick;
        logic [3:0] rx_bit;
        logic [8:0] rx_shift;
        asb_fmt_t rx_fmt;
        logic [2:0] votes;
        logic noise;
        logic [7:0] idle_cnt;
        logic idle_armed;
        logic mute;
        logic [8:0] rx_data;
        logic tx_complete;
        logic rx_full;
        logic idle_flag;
        logic overrun;
        logic noise_flag;
        logic framing;
        logic parity_err;
    } asb_state_t;

endpackage

// File: asb_remote.sv
// ****************************************
// Remote serial transceiver
// ****************************************
module asb_remote (
    // Clock
    input wire logic ref_clk,
    // Serial lines
    input wire logic tx_line,
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle line rests high, as a pulled-up line would
    initial rx_line = 1'b1;

    // Start, n bits lsb first, stop; bc cycles per bit
    task automatic send(input logic [8:0] d, input int n, input int bc);
        for (int i = -1; i <= n; i++)
        begin
            rx_line = (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
            repeat (bc) @(posedge ref_clk);
            #1;
        end
    endtask

    // Mid-bit samples after the start edge; bit n is the stop bit
    task automatic grab(output logic [9:0] d, input int n, input int bc);
        d = 10'h000;
        @(negedge tx_line);
        repeat (bc / 2) @(posedge ref_clk);
        for (int i = 0; i <= n; i++)
        begin
            repeat (bc) @(posedge ref_clk);
            d[i] = tx_line;
        end
        // Step off the edge so the caller drives clear of it
        #1;
    endtask
endmodule

// File: asb_serial_top.sv
`include "asb_consts.svh"

// ****************************************
// Transmit word buffer
// ****************************************
module asb_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 8
) (
    // Clock, reset, freeze
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic en,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } asb_fifo_state_t;

    asb_fifo_state_t q;
    asb_fifo_state_t d;
    logic push;
    logic pop;

    // Ready drops while frozen so no word is claimed but not stored
    assign in_ready = en && (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = en && (q.cnt != '0);
    assign out_data = q.mem[q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wr] = in_data;
            d.wr = q.wr + 1'b1;
        end
        if (pop)
        begin
            d.rd = q.rd + 1'b1;
        end
        if (push && !pop)
        begin
            d.cnt = q.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
endmodule

// ****************************************
// Serial core
// ****************************************
module asb_serial_top (
    // Clock, reset, freeze
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic halt_mode,
    input wire logic wait_mode,
    // Rate and frame setup
    input wire asb_pkg::asb_baud_t baud_rate_reg,
    input wire asb_pkg::asb_fmt_t frame_fmt,
    input wire logic wake_method,
    input wire logic tx_enable,
    input wire logic rx_enable,
    // Mute control
    input wire logic mute_set,
    output logic mute_request,
    // Interrupts
    input wire asb_pkg::asb_irq_en_t irq_enable,
    input wire logic global_irq_mask,
    output logic irq,
    output logic wait_exit,
    // Transmit words
    input wire logic tx_valid,
    input wire logic [8:0] tx_data,
    output logic tx_ready,
    // Received word and status
    input wire logic rx_read,
    output logic [8:0] rx_data,
    output asb_pkg::asb_status_t status,
    // Serial lines
    input wire logic rx_line,
    output logic tx_line
);
    asb_pkg::asb_state_t q;
    asb_pkg::asb_state_t d;
    logic run;
    logic [18:0] tx_reload;
    logic [18:0] rx_reload;
    logic tx_tick_p;
    logic rx_tick_p;
    logic maj;
    logic uniform;
    logic take;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [8:0] fifo_out_data;

    // Reload of one direction's tick counter: prescale times divisor times extension, less one
    function automatic logic [18:0] asb_reload(logic [1:0] ps, logic [2:0] ds, logic [7:0] ext);
        logic [3:0] pr;
        logic [7:0] e;
        logic [18:0] base;
        unique case (ps)
            2'h0: pr = `ASB_PR_SEL0;
            2'h1: pr = `ASB_PR_SEL1;
            2'h2: pr = `ASB_PR_SEL2;
            2'h3: pr = `ASB_PR_SEL3;
        endcase
        e = (ext == `ASB_EXT_BYPASS) ? 8'h01 : ext;
        base = {15'h0000, pr} << ds;
        asb_reload = 19'(base * {11'h000, e}) - 19'h00001;
    endfunction

    // Rate setup is read live; it is only safe because software holds it still
    assign tx_reload = asb_reload(baud_rate_reg.common_prescale_sel,
        baud_rate_reg.tx_divisor_sel, baud_rate_reg.tx_ext_prescale_reg);
    assign rx_reload = asb_reload(baud_rate_reg.common_prescale_sel,
        baud_rate_reg.rx_divisor_sel, baud_rate_reg.rx_ext_prescale_reg);

    // Halt stops everything; wait mode is deliberately not looked at here
    assign run = clk_en && !halt_mode;
    assign tx_tick_p = run && tx_enable && (q.tx_div == `ASB_DIV_RESET);
    assign rx_tick_p = run && rx_enable && (q.rx_div == `ASB_DIV_RESET);
    assign maj = (q.votes[0] && q.votes[1]) || (q.votes[0] && q.votes[2])
        || (q.votes[1] && q.votes[2]);
    assign uniform = (q.votes == 3'h0) || (q.votes == 3'h7);
    assign fifo_out_ready = run && tx_enable && !q.tx_busy;
    assign take = fifo_out_valid && fifo_out_ready;

    asb_fifo #(
        .W(`ASB_WORD_W),
        .DEPTH(`ASB_FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .en(run),
        .in_valid(tx_valid),
        .in_data(tx_data),
        .in_ready(tx_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );

    // Next state of the whole core
    always_comb
    begin
        logic [8:0] w;
        logic [8:0] word;
        logic msb;
        logic par_bad;
        logic frame_done;
        logic idle_evt;
        logic [7:0] idle_target;
        w = fifo_out_data;
        word = 9'h000;
        msb = 1'b0;
        par_bad = 1'b0;
        frame_done = 1'b0;
        idle_evt = 1'b0;
        idle_target = q.rx_fmt.word9 ? `ASB_IDLE_TICKS9 : `ASB_IDLE_TICKS8;
        d = q;
        if (run)
        begin
            // Two-stage line synchroniser
            d.rx_meta = rx_line;
            d.rx_sync = q.rx_meta;
            // Tick counters
            if (tx_enable)
            begin
                d.tx_div = tx_tick_p ? tx_reload : q.tx_div - 19'h00001;
            end
            if (rx_enable)
            begin
                d.rx_div = rx_tick_p ? rx_reload : q.rx_div - 19'h00001;
            end
            // Software clears first, so a hardware set in this cycle wins
            if (rx_read)
            begin
                d.rx_full = 1'b0;
                d.idle_flag = 1'b0;
                d.overrun = 1'b0;
                d.noise_flag = 1'b0;
                d.framing = 1'b0;
                d.parity_err = 1'b0;
            end
            if (tx_valid && tx_ready)
            begin
                d.tx_complete = 1'b0;
            end
            // Transmit: format latched per word, parity takes the msb place
            if (take)
            begin
                if (frame_fmt.parity_enable)
                begin
                    if (frame_fmt.word9)
                    begin
                        w[8] = ^w[7:0] ^ frame_fmt.odd_parity_select;
                    end
                    else
                    begin
                        w[7] = ^w[6:0] ^ frame_fmt.odd_parity_select;
                    end
                end
                d.tx_shift = frame_fmt.word9 ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
                d.tx_word9 = frame_fmt.word9;
                d.tx_busy = 1'b1;
                d.tx_tick = 4'h0;
                d.tx_bit = 4'h0;
                d.tx_line = 1'b0;
            end
            else if (q.tx_busy && tx_tick_p)
            begin
                d.tx_tick = q.tx_tick + 4'h1;
                if (q.tx_tick == `ASB_LAST_TICK)
                begin
                    if (q.tx_bit == (q.tx_word9 ? `ASB_TX_LAST_BIT9 : `ASB_TX_LAST_BIT8))
                    begin
                        d.tx_busy = 1'b0;
                        d.tx_line = `ASB_LINE_IDLE;
                        d.tx_complete = !fifo_out_valid;
                    end
                    else
                    begin
                        d.tx_bit = q.tx_bit + 4'h1;
                        d.tx_shift = {1'b1, q.tx_shift[10:1]};
                        d.tx_line = q.tx_shift[1];
                    end
                end
            end
            // Receive
            if (rx_tick_p)
            begin
                if (q.rx_ph == asb_pkg::ph_idle)
                begin
                    if (!q.rx_sync)
                    begin
                        // Falling edge restarts the sample count
                        d.rx_ph = asb_pkg::ph_start;
                        d.rx_tick = `ASB_START_TICK;
                        d.noise = 1'b0;
                        d.idle_cnt = 8'h00;
                        d.rx_fmt = frame_fmt;
                    end
                    else if (q.idle_cnt != idle_target)
                    begin
                        d.idle_cnt = q.idle_cnt + 8'h01;
                        idle_evt = (d.idle_cnt == idle_target);
                    end
                end
                else
                begin
                    d.rx_tick = q.rx_tick + 4'h1;
                    if (q.rx_tick >= `ASB_SAMPLE_FIRST && q.rx_tick <= `ASB_SAMPLE_LAST)
                    begin
                        d.votes = {q.votes[1:0], q.rx_sync};
                    end
                    if (q.rx_tick == `ASB_LAST_TICK)
                    begin
                        d.noise = q.noise || !uniform;
                        unique case (q.rx_ph)
                            asb_pkg::ph_idle:
                            begin
                                d.rx_ph = asb_pkg::ph_idle;
                            end
                            asb_pkg::ph_start:
                            begin
                                d.rx_ph = maj ? asb_pkg::ph_idle : asb_pkg::ph_data;
                                d.rx_bit = 4'h0;
                            end
                            asb_pkg::ph_data:
                            begin
                                d.rx_shift = {maj, q.rx_shift[8:1]};
                                d.rx_bit = q.rx_bit + 4'h1;
                                if (q.rx_bit == (q.rx_fmt.word9 ? `ASB_RX_LAST_BIT9
                                    : `ASB_RX_LAST_BIT8))
                                begin
                                    d.rx_ph = asb_pkg::ph_stop;
                                end
                            end
                            asb_pkg::ph_stop:
                            begin
                                frame_done = 1'b1;
                                d.rx_ph = asb_pkg::ph_idle;
                                d.idle_cnt = 8'h00;
                            end
                        endcase
                    end
                end
            end
            // Frame end: store, flag, or drop while muted
            if (frame_done)
            begin
                word = q.rx_fmt.word9 ? q.rx_shift : {1'b0, q.rx_shift[8:1]};
                // With parity on, the msb place holds parity, so the data msb sits one lower
                if (q.rx_fmt.parity_enable)
                begin
                    msb = q.rx_fmt.word9 ? word[7] : word[6];
                end
                else
                begin
                    msb = q.rx_fmt.word9 ? word[8] : word[7];
                end
                par_bad = q.rx_fmt.parity_enable
                    && ((^word) != q.rx_fmt.odd_parity_select);
                if (!q.mute || (wake_method && msb))
                begin
                    d.mute = 1'b0;
                    if (q.rx_full)
                    begin
                        d.overrun = 1'b1;
                    end
                    else
                    begin
                        d.rx_data = word;
                        d.rx_full = 1'b1;
                        d.idle_armed = 1'b1;
                        d.noise_flag = d.noise;
                        d.framing = !maj;
                        d.parity_err = par_bad;
                    end
                end
            end
            // Idle line: under idle wake, wakes a muted receiver silently; else flags once if not muted
            if (idle_evt)
            begin
                if (q.mute && !wake_method)
                begin
                    d.mute = 1'b0;
                end
                else if (!q.mute && q.idle_armed)
                begin
                    d.idle_flag = 1'b1;
                    d.idle_armed = 1'b0;
                end
            end
            // Software request wins; a late write re-mutes, hence no writes while muted
            if (mute_set)
            begin
                d.mute = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            q <= '0;
            q.rx_meta <= `ASB_LINE_IDLE;
            q.rx_sync <= `ASB_LINE_IDLE;
            q.tx_line <= `ASB_LINE_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    // Status view and interrupt line
    always_comb
    begin
        status.tx_empty_flag = tx_ready;
        status.tx_complete_flag = q.tx_complete;
        status.rx_full_flag = q.rx_full;
        status.idle_flag = q.idle_flag;
        status.overrun_flag = q.overrun;
        status.noise_flag = q.noise_flag;
        status.framing_flag = q.framing;
        status.parity_error_flag = q.parity_err;
    end

    // Noise and framing raise nothing: they arrive together with the full flag
    assign irq = !global_irq_mask && ((irq_enable.tx_empty_irq_enable && tx_ready)
        || (irq_enable.tx_complete_irq_enable && q.tx_complete)
        || (irq_enable.rx_irq_enable && (q.rx_full || q.overrun))
        || (irq_enable.idle_irq_enable && q.idle_flag)
        || (irq_enable.parity_irq_enable && q.parity_err));
    assign wait_exit = wait_mode && irq;
    assign mute_request = q.mute;
    assign rx_data = q.rx_data;
    assign tx_line = q.tx_line;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_take;
        take;
    endsequence

    sequence s_edge_seen;
        rx_tick_p && q.rx_ph == asb_pkg::ph_idle && !q.rx_sync;
    endsequence

    a_tx_start_bit: assert property (s_take |=> !tx_line && q.tx_busy)
        else $error("Start bit not driven after load");
    a_rx_realign: assert property (s_edge_seen |=> q.rx_ph == asb_pkg::ph_start
        && q.rx_tick == 4'h1)
        else $error("Receiver did not realign on start");
    a_halt_freeze: assert property (halt_mode |=> $stable(q))
        else $error("State moved during halt");
    a_irq_masked: assert property (global_irq_mask |-> !irq)
        else $error("Interrupt raised while masked");
    a_rx_irq_gate: assert property (!global_irq_mask && irq_enable.rx_irq_enable
        && q.overrun |-> irq)
        else $error("Overrun did not raise interrupt");
    a_mute_no_idle: assert property ($rose(q.idle_flag) |-> !$past(q.mute))
        else $error("Idle flag set while muted");
    a_idle_wake_quiet: assert property ($fell(q.mute) && !wake_method
        && !$past(rx_read) |-> !$rose(q.idle_flag))
        else $error("Idle wake also set idle flag");
    a_addr_wake_full: assert property ($fell(q.mute) && wake_method |-> q.rx_full)
        else $error("Address wake left full flag clear");
    a_parity_only_on: assert property ($rose(q.parity_err)
        |-> $past(q.rx_fmt.parity_enable))
        else $error("Parity error without parity enabled");
endmodule

// File: asb_serial_top_bench.sv
// ****************************************
// Serial core bench
// ****************************************
module asb_serial_top_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // Drives and observations
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic wait_mode = 1'b0;
    logic halt = 1'b0;
    logic cen = 1'b1;
    logic [23:0] baud = 24'h000000;
    logic [2:0] fmt = 3'h0;
    logic wake = 1'b0;
    logic tx_en = 1'b1;
    logic rx_en = 1'b1;
    logic mute_set = 1'b0;
    logic [4:0] ien = 5'h00;
    logic gmask = 1'b0;
    logic tx_valid = 1'b0;
    logic [8:0] tx_data = 9'h000;
    logic rx_read = 1'b0;
    logic mute_req, irq, wexit, tx_ready, rx_line, tx_line;
    logic [8:0] rx_data;
    asb_pkg::asb_status_t st;
    logic [9:0] w;
    int pr [4] = '{1, 3, 4, 13};
    int n_errors = 0;
    int n_compared = 0;

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    // Core and its remote end
    asb_serial_top dut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(cen), .halt_mode(halt),
        .wait_mode(wait_mode), .baud_rate_reg(baud), .frame_fmt(fmt),
        .wake_method(wake), .tx_enable(tx_en), .rx_enable(rx_en),
        .mute_set(mute_set), .mute_request(mute_req), .irq_enable(ien),
        .global_irq_mask(gmask), .irq(irq), .wait_exit(wexit),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .rx_read(rx_read), .rx_data(rx_data), .status(st),
        .rx_line(rx_line), .tx_line(tx_line)
    );
    asb_remote u_remote (.ref_clk(ref_clk), .tx_line(tx_line), .rx_line(rx_line));

    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Inputs always change 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Valid stays up across words, so no double assignment in a step
    task automatic push(input logic [8:0] d, input int n);
        tx_valid = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            tx_data = d + 9'(i);
            while (tx_ready !== 1'b1)
                cyc(1);
            cyc(1);
        end
        tx_valid = 1'b0;
    endtask

    task automatic rd;
        rx_read = 1'b1;
        cyc(1);
        rx_read = 1'b0;
        cyc(1);
    endtask

    task automatic txf(input logic [8:0] d, input int n, input int bc, input logic [9:0] e);
        fork
            u_remote.grab(w, n, bc);
            push(d, 1);
        join
        chk(12'(w), 12'(e));
    endtask

    // Flags land up to one tick plus the sync delay after the stop bit
    task automatic rxf(input logic [8:0] d, input int n, input int bc);
        u_remote.send(d, n, bc);
        cyc(bc / 16 + 4);
    endtask

    // Rates only change with both directions disabled
    task automatic setb(input logic [23:0] b);
        tx_en = 1'b0;
        rx_en = 1'b0;
        cyc(1);
        baud = b;
        cyc(1);
        tx_en = 1'b1;
        rx_en = 1'b1;
    endtask

    function automatic int bitc(input logic [2:0] d, input logic [7:0] x);
        return 16 * pr[baud[23:22]] * (1 << d) * ((x == 8'h00) ? 1 : int'(x));
    endfunction

    task automatic t_tx;
        chk({mute_req, irq, tx_line, st}, {3'h1, 8'h80});
        ien = 5'h08;
        txf(9'h0a5, 8, 16, 10'h1a5);
        cyc(12);
        wait_mode = 1'b1;
        cyc(1);
        chk({st.tx_complete_flag, irq, wexit}, 3'h7);
        gmask = 1'b1;
        cyc(1);
        chk({irq, wexit}, 2'h0);
        gmask = 1'b0;
        ien = 5'h10;
        cyc(1);
        chk(irq, 1'b1);
    endtask

    // Written msb is 1 for 8-bit words but 0 for 9-bit words (9'h0b5), so a leak shows in 8-bit
    task automatic t_par_tx;
        logic p;
        for (int m = 0; m < 2; m++)
            for (int ps = 0; ps < 2; ps++)
            begin
                fmt = {m[0], 1'b1, ps[0]};
                p = ^(m[0] ? 8'hb5 : 8'h35) ^ ps[0];
                txf(9'h0b5, 8 + m, 16, m[0] ? {1'b1, p, 8'hb5} : {2'h1, p, 7'h35});
            end
        fmt = 3'h0;
    endtask

    task automatic t_rx;
        ien = 5'h04;
        rxf(9'h05a, 8, 16);
        chk({st.rx_full_flag, irq, rx_data}, {2'h3, 9'h05a});
        rxf(9'h033, 8, 16);
        chk({st.overrun_flag, irq, rx_data}, {2'h3, 9'h05a});
        rd;
        fmt = 3'h4;
        rxf(9'h1c3, 9, 16);
        chk({st[5:0], rx_data}, {6'h20, 9'h1c3});
        rd;
        fmt = 3'h2;
        ien = 5'h01;
        rxf(9'h0b5, 8, 16);
        chk({st.parity_error_flag, irq}, 2'h3);
        rd;
        fmt = 3'h3;
        rxf(9'h0b5, 8, 16);
        chk({st.rx_full_flag, st.parity_error_flag, irq}, 3'h4);
        rd;
        fmt = 3'h0;
    endtask

    task automatic t_mute;
        ien = 5'h04;
        wake = 1'b1;
        mute_set = 1'b1;
        cyc(1);
        mute_set = 1'b0;
        rxf(9'h012, 8, 16);
        chk({st.rx_full_flag, irq, mute_req}, 3'h1);
        rxf(9'h081, 8, 16);
        chk({st.rx_full_flag, mute_req, rx_data}, {2'h2, 9'h081});
        ien = 5'h02;
        cyc(200);
        chk({st.idle_flag, irq}, 2'h3);
        rd;
        wake = 1'b0;
        mute_set = 1'b1;
        cyc(1);
        mute_set = 1'b0;
        rxf(9'h000, 8, 16);
        chk(mute_req, 1'b1);
        cyc(200);
        chk({mute_req, st.idle_flag}, 2'h0);
        // Parity holds the msb place; only the data msb may wake
        wake = 1'b1;
        fmt = 3'h2;
        mute_set = 1'b1;
        cyc(1);
        mute_set = 1'b0;
        rxf(9'h081, 8, 16);
        chk({st.rx_full_flag, mute_req}, 2'h1);
        rxf(9'h0c0, 8, 16);
        chk({st.rx_full_flag, mute_req, st.parity_error_flag, rx_data}, {3'h4, 9'h0c0});
        rd;
        fmt = 3'h0;
        wake = 1'b0;
    endtask

    // Freeze mid-frame by halt, then by clock enable; the frame must resume, not finish
    task automatic t_halt;
        ien = 5'h10;
        push(9'h002, 1);
        cyc(40);
        halt = 1'b1;
        cyc(150);
        halt = 1'b0;
        cen = 1'b0;
        cyc(150);
        chk({tx_ready, irq, st.tx_complete_flag, tx_line}, 4'h1);
        cen = 1'b1;
        cyc(100);
        chk({tx_ready, irq, st.tx_complete_flag}, 3'h6);
        cyc(30);
        chk(st.tx_complete_flag, 1'b1);
    endtask

    // Fill while stalled, then drain all eight in order
    task automatic t_fifo;
        tx_en = 1'b0;
        push(9'h010, 8);
        chk({tx_ready, st.tx_empty_flag}, 2'h0);
        tx_en = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            u_remote.grab(w, 8, 16);
            chk(12'(w), 12'h110 + 12'(i));
        end
    endtask

    task automatic t_rate;
        logic [23:0] rows [4] = '{24'h480003, 24'hc10100, 24'h930000, 24'h000509};
        for (int r = 0; r < 4; r++)
        begin
            setb(rows[r]);
            txf(9'h05a, 8, bitc(baud[21:19], baud[15:8]), 10'h15a);
            rxf(9'h0a6, 8, bitc(baud[18:16], baud[7:0]));
            chk({st.rx_full_flag, rx_data}, {1'b1, 9'h0a6});
            rd;
        end
    endtask

    // Main sequence
    initial
    begin
        cyc(3);
        reset = 1'b0;
        t_tx;
        t_par_tx;
        t_rx;
        t_mute;
        t_halt;
        t_fifo;
        t_rate;
        end_sim;
    end

    // Watchdog; the sequence needs about 23000 cycles
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        n_errors++;
        end_sim;
    end
endmodule
